// *** verif/cebp_bus_monitor.sv ***
// Checker on the carrier between the core end and the target end.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
module cebp_bus_monitor
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // Carrier signals
    input wire logic address_valid,
    input wire logic address_ready,
    input wire logic [35:2] bus_word_address,
    input wire logic [3:0] byte_lane_enables,
    input wire logic [1:0] burst_length_code,
    input wire logic [31:0] write_data_bus,
    input wire logic read_data_valid,
    input wire logic write_data_ready,
    input wire logic read_bus_error,
    input wire logic write_bus_error,
    input wire logic external_buffers_empty,
    input wire logic waiting_for_buffers_empty
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    wire [31:0] lane_mask = {{8{byte_lane_enables[3]}},
        {8{byte_lane_enables[2]}}, {8{byte_lane_enables[1]}},
        {8{byte_lane_enables[0]}}};

    blen_code_a: assert property (burst_length_code == 2'h1)
        else $error("burst code not four beats");
    addr_top_a: assert property (address_valid |->
        bus_word_address[35:32] == 4'h0) else $error("address top set");
    lane_zero_a: assert property (write_data_ready |->
        (write_data_bus & ~lane_mask) == 32'h0)
        else $error("disabled write lane driven");
    addr_hold_a: assert property (address_valid && !address_ready |=>
        address_valid && $stable(bus_word_address))
        else $error("address dropped before ready");
    addr_done_a: assert property (address_valid && address_ready |=>
        !address_valid) else $error("address phase not ended");
    rerr_valid_a: assert property (read_bus_error |->
        read_data_valid) else $error("read error outside transfer");
    werr_ready_a: assert property (write_bus_error |->
        write_data_ready) else $error("write error without ready");
    empty_drop_a: assert property (write_data_ready |=>
        !external_buffers_empty) else $error("buffers empty after beat");
    wait_hold_a: assert property (waiting_for_buffers_empty &&
        !external_buffers_empty |=> waiting_for_buffers_empty)
        else $error("wait left while buffers busy");
    wait_end_a: assert property (waiting_for_buffers_empty &&
        external_buffers_empty |=> !waiting_for_buffers_empty)
        else $error("wait kept after buffers empty");
endmodule

// *** verif/testbench.sv ***
// Self-checking bench: both ends joined by the carrier.
// Assumes a 25 MHz clock; inputs change only on the rising edge.
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
    import cebp_pkg::*;
;
    typedef struct {bit w; bit b; logic [29:0] a; logic [3:0] be;
        logic [31:0] d; bit er;} cebp_row_t;
    logic sys_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic req_valid_in = 1'b0, req_write_in = 1'b0, req_burst_in = 1'b0;
    logic [29:0] req_addr_in = 30'h0;
    logic [3:0] req_be_in = 4'h0;
    logic wbeat_valid_in = 1'b0, sync_req_in = 1'b0;
    logic [31:0] wbeat_data_in = 32'h0;
    logic order_sel = 1'b1, drain_hold = 1'b0;
    logic req_ready_out, wbeat_ready_out, sync_done_out, rd_valid_out;
    logic [31:0] rd_data_out;
    logic [1:0] rd_word_out;
    logic rd_err_out, wr_done_out, wr_err_out;
    logic [31:0] exp_mem [256];
    logic [35:2] last_a;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    // Error rows address past the 256-word memory
    cebp_row_t rows [8] = '{'{1, 1, 30'h10, 4'hF, 32'hA0A0_0000, 0},
        '{1, 0, 30'h21, 4'hF, 32'h1122_3344, 0},
        '{1, 0, 30'h21, 4'h5, 32'h5566_7788, 0},
        '{0, 0, 30'h21, 4'hF, 32'h0, 0}, '{0, 1, 30'h13, 4'hF, 32'h0, 0},
        '{0, 0, 30'h12, 4'h6, 32'h0, 0}, '{1, 0, 30'h100, 4'hF, 32'h1, 1},
        '{0, 0, 30'h100, 4'hF, 32'h0, 1}};
    cebp_bus_if bif();
    always #20 sys_clk_in = ~sys_clk_in;

    cebp_core_end i_cebp_core_end (.sys_clk_in, .nrst_in, .bus(bif),
        .req_valid_in, .req_write_in, .req_burst_in, .req_addr_in,
        .req_be_in, .req_ready_out, .wbeat_valid_in, .wbeat_data_in,
        .wbeat_ready_out, .sync_req_in, .sync_done_out, .rd_valid_out,
        .rd_data_out, .rd_word_out, .rd_err_out, .wr_done_out, .wr_err_out);
    cebp_target_end i_cebp_target_end (.sys_clk_in, .nrst_in, .bus(bif),
        .order_select_in(order_sel), .drain_hold_in(drain_hold));
    cebp_bus_monitor i_cebp_bus_monitor (.sys_clk_in, .nrst_in,
        .address_valid(bif.address_valid),
        .address_ready(bif.address_ready),
        .bus_word_address(bif.bus_word_address),
        .byte_lane_enables(bif.byte_lane_enables),
        .burst_length_code(bif.burst_length_code),
        .write_data_bus(bif.write_data_bus),
        .read_data_valid(bif.read_data_valid),
        .write_data_ready(bif.write_data_ready),
        .read_bus_error(bif.read_bus_error),
        .write_bus_error(bif.write_bus_error),
        .external_buffers_empty(bif.external_buffers_empty),
        .waiting_for_buffers_empty(bif.waiting_for_buffers_empty));

    always @(posedge sys_clk_in)
        if (bif.address_valid) last_a <= bif.bus_word_address;

    function automatic logic [31:0] lmask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction
    // Word of beat k in the strapped order
    function automatic logic [7:0] widx(input logic [29:0] a, input int k);
        logic [1:0] w;
        w = order_sel ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k);
        return {a[7:2], w};
    endfunction

    task automatic req(input cebp_row_t r);
        @(posedge sys_clk_in);
        req_valid_in <= 1'b1;
        req_write_in <= r.w;
        req_burst_in <= r.b;
        req_addr_in <= r.a;
        req_be_in <= r.be;
        do @(negedge sys_clk_in); while (!req_ready_out);
        @(posedge sys_clk_in);
        req_valid_in <= 1'b0;
    endtask

    task automatic wr(input cebp_row_t r);
        logic [7:0] i;
        req(r);
        for (int k = 0; k < (r.b ? 4 : 1); k++)
        begin
            wbeat_valid_in <= 1'b1;
            wbeat_data_in <= r.d + 32'(k);
            do @(negedge sys_clk_in); while (!wbeat_ready_out);
            @(posedge sys_clk_in);
        end
        wbeat_valid_in <= 1'b0;
        do @(negedge sys_clk_in); while (!wr_done_out);
        `CHK(wr_err_out, r.er)
        for (int k = 0; k < (r.b ? 4 : 1) && !r.er; k++)
        begin
            i = widx(r.a, k);
            exp_mem[i] = (exp_mem[i] & ~lmask(r.be)) |
                ((r.d + 32'(k)) & lmask(r.be));
        end
    endtask

    task automatic rd(input cebp_row_t r);
        logic [7:0] i;
        req(r);
        for (int k = 0; k < (r.b ? 4 : 1); k++)
        begin
            do @(negedge sys_clk_in); while (!rd_valid_out);
            i = widx(r.a, k);
            `CHK(rd_word_out, i[1:0])
            `CHK(rd_data_out, r.er ? 32'h0 : exp_mem[i] & lmask(r.be))
            `CHK(rd_err_out, r.er)
        end
        if (!r.b) `CHK(last_a, {4'h0, r.a})
    endtask

    task automatic final_report;
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge sys_clk_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            final_report;
        end
    end

    initial
    begin
        repeat (5) @(posedge sys_clk_in);
        `CHK(bif.address_ready, 1'b1)
        `CHK(bif.external_buffers_empty, 1'b1)
        `CHK(bif.address_valid, 1'b0)
        nrst_in <= 1'b1;
        foreach (rows[n])
        begin
            if (rows[n].w)
                wr(rows[n]);
            else
                rd(rows[n]);
            $display("row %0d done", n);
        end
        // Held drain lets four bursts fill the buffer
        @(posedge sys_clk_in);
        drain_hold <= 1'b1;
        for (int n = 0; n < 4; n++)
            wr('{1, 1, 30'h40 + 30'(4 * n), 4'hF, 32'hB0 + 32'(16 * n), 0});
        fork
            wr('{1, 0, 30'h50, 4'hF, 32'hC0DE_0001, 0});
            begin
                repeat (8) @(negedge sys_clk_in);
                `CHK(bif.write_data_ready, 1'b0)
                `CHK(bif.external_buffers_empty, 1'b0)
                @(posedge sys_clk_in);
                drain_hold <= 1'b0;
            end
        join
        rd('{0, 1, 30'h4D, 4'hF, 32'h0, 0});
        $display("fill test done");
        @(posedge sys_clk_in);
        drain_hold <= 1'b1;
        wr('{1, 0, 30'h51, 4'h9, 32'hD00D_F00D, 0});
        @(posedge sys_clk_in);
        sync_req_in <= 1'b1;
        do @(negedge sys_clk_in); while (!bif.waiting_for_buffers_empty);
        @(posedge sys_clk_in);
        sync_req_in <= 1'b0;
        repeat (4) @(negedge sys_clk_in);
        `CHK(bif.waiting_for_buffers_empty, 1'b1)
        `CHK(sync_done_out, 1'b0)
        @(posedge sys_clk_in);
        drain_hold <= 1'b0;
        do @(negedge sys_clk_in); while (!sync_done_out);
        `CHK(bif.external_buffers_empty, 1'b1)
        `CHK(bif.waiting_for_buffers_empty, 1'b0)
        $display("sync test done");
        // Second reset switches the strap to linear order
        @(posedge sys_clk_in);
        nrst_in <= 1'b0;
        order_sel <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        rd('{0, 1, 30'h11, 4'hF, 32'h0, 0});
        rd('{0, 0, 30'h51, 4'h9, 32'h0, 0});
        $display("order test done");
        final_report;
    end
endmodule

// *** verilog/cebp_bus_if.sv ***
// Carrier of the external bus between the core end and the target end.
// Both ends sit on the same clock; no synchronisers are needed.
`timescale 1ns/1ns
interface cebp_bus_if;
    logic address_valid;
    logic address_ready;
    logic [35:2] bus_word_address;
    logic [3:0] byte_lane_enables;
    logic [1:0] burst_length_code;
    logic burst;
    logic write;
    logic [31:0] write_data_bus;
    logic [31:0] read_data_bus;
    logic read_data_valid;
    logic write_data_ready;
    logic read_bus_error;
    logic write_bus_error;
    logic external_buffers_empty;
    logic waiting_for_buffers_empty;
    logic subblock_order_select;

    modport core (
        output address_valid, bus_word_address, byte_lane_enables,
        output burst_length_code, burst, write, write_data_bus,
        output waiting_for_buffers_empty,
        input address_ready, read_data_bus, read_data_valid,
        input write_data_ready, read_bus_error, write_bus_error,
        input external_buffers_empty, subblock_order_select
    );

    modport target (
        input address_valid, bus_word_address, byte_lane_enables,
        input burst_length_code, burst, write, write_data_bus,
        input waiting_for_buffers_empty,
        output address_ready, read_data_bus, read_data_valid,
        output write_data_ready, read_bus_error, write_bus_error,
        output external_buffers_empty, subblock_order_select
    );
endinterface

// *** verilog/cebp_core_end.sv ***
// Core (bus master) end of the external bus port.
// Assumes a target end on the same clock keeps the far-side handshakes.
//
// Contract
// RQ1: Burst length code is always one (four beats).
// RQ2: System holds burst order select static.
// RQ3: Byte lane enables qualify each data byte.
// RQ4: Word address valid while address valid high.
// RQ5: Top four address bits are always zero.
// RQ6: Target flags each cycle of valid read data.
// RQ7: Target signals write ready; core holds data.
// RQ8: Read error taken with valid read data.
// RQ9: Target keeps read error low when idle.
// RQ10: Write error evaluated with accepted write ready.
// RQ11: Buffers-empty high only with nothing pending.
// RQ12: Buffers-empty drops after write ready, stays low.
// RQ13: Waiting output high while stalled on buffers.
// RQ14: Address phase ends cycle after ready sampled.
// RQ15: Address valid marks new transaction, always defined.
`timescale 1ns/1ns
module cebp_core_end
    import cebp_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // External bus
    cebp_bus_if.core bus,
    // Transaction request
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic req_burst_in,
    input wire logic [REQ_ADDR_W-1:0] req_addr_in,
    input wire logic [BE_W-1:0] req_be_in,
    output logic req_ready_out,
    // Write words, gathered before the address phase
    input wire logic wbeat_valid_in,
    input wire logic [DATA_W-1:0] wbeat_data_in,
    output logic wbeat_ready_out,
    // Buffer drain barrier
    input wire logic sync_req_in,
    output logic sync_done_out,
    // Read answers
    output logic rd_valid_out,
    output logic [DATA_W-1:0] rd_data_out,
    output logic [1:0] rd_word_out,
    output logic rd_err_out,
    // Write completion
    output logic wr_done_out,
    output logic wr_err_out
);
    cebp_core_st_t state_ff;
    cebp_core_st_t nxt_state;
    logic [REQ_ADDR_W-1:0] addr_ff;
    logic [BE_W-1:0] be_ff;
    logic wr_ff;
    logic burst_ff;
    logic [1:0] beat_ff;
    logic [1:0] nxt_beat;
    logic [DATA_W-1:0] wbuf_ff [BURST_BEATS];
    logic [DATA_W-1:0] wout_ff;
    logic [DATA_W-1:0] rd_data_ff;
    logic rd_valid_ff;
    logic rd_err_ff;
    logic [1:0] rd_word_ff;
    logic wr_done_ff;
    logic wr_err_ff;
    logic wr_err_acc_ff;
    logic sync_done_ff;

    wire logic [DATA_W-1:0] lane_mask;
    wire logic [1:0] last_beat;
    wire logic at_last;
    wire logic [1:0] ord_word;
    wire logic take_req;
    wire logic take_sync;
    wire logic fill_beat;
    wire logic addr_done;
    wire logic rd_beat;
    wire logic wr_beat;

    // One mask byte per lane, all ones where the lane is enabled
    genvar lane;
    generate
        for (lane = 0; lane < BE_W; lane++)
        begin : g_lane
            assign lane_mask[lane*LANE_W +: LANE_W] =
                {LANE_W{be_ff[lane]}}; // RQ3
        end
    endgenerate

    assign last_beat = burst_ff ? BEAT_LAST_BURST : BEAT_LAST_SINGLE;
    assign at_last = (beat_ff == last_beat);
    assign nxt_beat = beat_ff + BEAT_STEP;
    // Word of the line that the current beat carries
    assign ord_word = bus.subblock_order_select ?
        (addr_ff[1:0] ^ beat_ff) : (addr_ff[1:0] + beat_ff); // RQ2

    assign take_req = (state_ff == CEBP_C_IDLE) && req_valid_in;
    assign take_sync = (state_ff == CEBP_C_IDLE) && !req_valid_in &&
        sync_req_in;
    assign fill_beat = (state_ff == CEBP_C_FILL) && wbeat_valid_in;
    // Address phase closes one cycle after ready is seen high
    assign addr_done = (state_ff == CEBP_C_ADDR) &&
        bus.address_ready; // RQ14
    assign rd_beat = (state_ff == CEBP_C_READ) &&
        bus.read_data_valid; // RQ8
    assign wr_beat = (state_ff == CEBP_C_WRITE) &&
        bus.write_data_ready; // RQ7

    assign req_ready_out = (state_ff == CEBP_C_IDLE);
    assign wbeat_ready_out = (state_ff == CEBP_C_FILL);

    // Bus outputs
    assign bus.address_valid = (state_ff == CEBP_C_ADDR); // RQ15
    assign bus.bus_word_address = {ADDR_TOP_ZERO, addr_ff}; // RQ4 RQ5
    assign bus.byte_lane_enables = be_ff; // RQ3
    assign bus.burst_length_code = BLEN_FOUR; // RQ1
    assign bus.burst = burst_ff;
    assign bus.write = wr_ff;
    assign bus.write_data_bus = wout_ff;
    assign bus.waiting_for_buffers_empty =
        (state_ff == CEBP_C_WAITB); // RQ13

    assign rd_valid_out = rd_valid_ff;
    assign rd_data_out = rd_data_ff;
    assign rd_word_out = rd_word_ff;
    assign rd_err_out = rd_err_ff;
    assign wr_done_out = wr_done_ff;
    assign wr_err_out = wr_err_ff;
    assign sync_done_out = sync_done_ff;

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            CEBP_C_IDLE:
            begin
                if (take_req)
                    nxt_state = req_write_in ? CEBP_C_FILL : CEBP_C_ADDR;
                else if (take_sync)
                    nxt_state = CEBP_C_WAITB;
            end
            CEBP_C_FILL:
            begin
                if (fill_beat && at_last)
                    nxt_state = CEBP_C_ADDR;
            end
            CEBP_C_ADDR:
            begin
                if (addr_done)
                    nxt_state = wr_ff ? CEBP_C_WRITE : CEBP_C_READ;
            end
            CEBP_C_READ:
            begin
                if (rd_beat && at_last)
                    nxt_state = CEBP_C_IDLE;
            end
            CEBP_C_WRITE:
            begin
                if (wr_beat && at_last)
                    nxt_state = CEBP_C_IDLE;
            end
            CEBP_C_WAITB:
            begin
                // Stall lasts until every external buffer has drained
                if (bus.external_buffers_empty)
                    nxt_state = CEBP_C_IDLE; // RQ13
            end
            default:
                nxt_state = CEBP_C_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            state_ff <= CEBP_C_IDLE;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            addr_ff <= REQ_ADDR_ZERO;
            be_ff <= BE_ZERO;
            wr_ff <= 1'b0;
            burst_ff <= 1'b0;
        end
        else if (take_req)
        begin
            addr_ff <= req_addr_in;
            be_ff <= req_be_in;
            wr_ff <= req_write_in;
            burst_ff <= req_burst_in;
        end
    end

    // One beat counter serves gathering, reading and writing
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            beat_ff <= BEAT_FIRST;
        else if (take_req || addr_done || (fill_beat && at_last))
            beat_ff <= BEAT_FIRST;
        else if (fill_beat || rd_beat || wr_beat)
            beat_ff <= nxt_beat;
    end

    // Disabled lanes are zeroed at gathering time
    always_ff @(posedge sys_clk_in)
    begin
        if (fill_beat)
            wbuf_ff[beat_ff] <= wbeat_data_in & lane_mask; // RQ3
    end

    // Write word stays put until the target takes it
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            wout_ff <= DATA_ZERO;
        else if (addr_done)
            wout_ff <= wbuf_ff[BEAT_FIRST];
        else if (wr_beat && !at_last)
            wout_ff <= wbuf_ff[nxt_beat]; // RQ7
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rd_valid_ff <= 1'b0;
            rd_err_ff <= 1'b0;
            rd_data_ff <= DATA_ZERO;
            rd_word_ff <= BEAT_FIRST;
        end
        else
        begin
            rd_valid_ff <= rd_beat;
            rd_err_ff <= rd_beat && bus.read_bus_error; // RQ8
            if (rd_beat)
            begin
                rd_data_ff <= bus.read_data_bus & lane_mask; // RQ3
                rd_word_ff <= ord_word;
            end
        end
    end

    // Error of any beat of a write is reported once at its end
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            wr_err_acc_ff <= 1'b0;
            wr_done_ff <= 1'b0;
            wr_err_ff <= 1'b0;
        end
        else
        begin
            wr_done_ff <= wr_beat && at_last;
            wr_err_ff <= wr_beat && at_last &&
                (wr_err_acc_ff || bus.write_bus_error); // RQ10
            if (addr_done)
                wr_err_acc_ff <= 1'b0;
            else if (wr_beat)
                wr_err_acc_ff <= wr_err_acc_ff ||
                    bus.write_bus_error; // RQ10
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            sync_done_ff <= 1'b0;
        else
            sync_done_ff <= (state_ff == CEBP_C_WAITB) &&
                bus.external_buffers_empty;
    end
endmodule

// *** verilog/cebp_pkg.sv ***
// Shared constants and state types of the external bus port.
// Assumes both ends run on one clock and one asynchronous active-low reset.
package cebp_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BE_W = 4;
    localparam int unsigned LANE_W = 8;
    localparam int unsigned BLEN_W = 2;
    localparam int unsigned REQ_ADDR_W = 30;
    localparam int unsigned BURST_BEATS = 4;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned MEM_WORDS = 256;
    // Only code value 1 (four beats) is ever driven
    localparam logic [1:0] BLEN_FOUR = 2'h1;
    localparam logic [1:0] BEAT_FIRST = 2'h0;
    localparam logic [1:0] BEAT_LAST_BURST = 2'h3;
    localparam logic [1:0] BEAT_LAST_SINGLE = 2'h0;
    localparam logic [1:0] BEAT_STEP = 2'h1;
    localparam logic [3:0] ADDR_TOP_ZERO = 4'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
    localparam logic [BE_W-1:0] BE_ZERO = 4'h0;
    localparam logic [REQ_ADDR_W-1:0] REQ_ADDR_ZERO = 30'h0000_0000;
    localparam logic [35:2] BUS_ADDR_ZERO = 34'h0_0000_0000;

    typedef enum logic [2:0] {
        CEBP_C_IDLE = 3'h0,
        CEBP_C_FILL = 3'h1,
        CEBP_C_ADDR = 3'h2,
        CEBP_C_READ = 3'h3,
        CEBP_C_WRITE = 3'h4,
        CEBP_C_WAITB = 3'h5
    } cebp_core_st_t;

    typedef enum logic [1:0] {
        CEBP_T_IDLE = 2'h0,
        CEBP_T_READ = 2'h1,
        CEBP_T_WRITE = 2'h2
    } cebp_tgt_st_t;
endpackage

// *** verilog/cebp_target_end.sv ***
// Target end: word memory behind a posted write buffer FIFO.
// Assumes the core end on the same clock drives the requests.
`timescale 1ns/1ns
module cebp_fifo
#(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 16
)
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // Fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int unsigned PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] PTR_ONE = (PTR_W+1)'(1);
    localparam logic [PTR_W:0] DEPTH_CNT = DEPTH[PTR_W:0];
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff;
    logic [PTR_W-1:0] rd_ptr_ff;
    logic [PTR_W:0] count_ff;
    wire logic push;
    wire logic pop;

    assign in_ready_out = (count_ff != DEPTH_CNT);
    assign out_valid_out = (count_ff != '0);
    assign out_data_out = mem_ff[rd_ptr_ff];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_ff @(posedge sys_clk_in)
    begin
        if (push)
            mem_ff[wr_ptr_ff] <= in_data_in;
    end

    // Pointers wrap only for power-of-two depths
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_ff <= wr_ptr_ff + PTR_ONE[PTR_W-1:0];
            if (pop)
                rd_ptr_ff <= rd_ptr_ff + PTR_ONE[PTR_W-1:0];
            if (push && !pop)
                count_ff <= count_ff + PTR_ONE;
            else if (pop && !push)
                count_ff <= count_ff - PTR_ONE;
        end
    end
endmodule

module cebp_target_end
    import cebp_pkg::*;
#(
    parameter int unsigned WORDS = MEM_WORDS,
    parameter int unsigned DEPTH = FIFO_DEPTH
)
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // External bus
    cebp_bus_if.target bus,
    // System straps and drain control
    input wire logic order_select_in,
    input wire logic drain_hold_in
);
    localparam int unsigned IDX_W = $clog2(WORDS);
    localparam int unsigned ENT_W = 1 + IDX_W + BE_W + DATA_W;
    cebp_tgt_st_t state_ff;
    logic [35:2] addr_ff;
    logic burst_ff;
    logic [1:0] beat_ff;
    logic order_meta_ff, order_ff;
    logic rdv_ff;
    logic rberr_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] mem_ff [WORDS];

    wire logic in_range;
    wire logic [1:0] ord_word;
    wire logic [IDX_W-1:0] idx;
    wire logic at_last;
    wire logic take_addr;
    wire logic rd_go;
    wire logic wr_go;
    wire logic fifo_in_ready;
    wire logic fifo_out_valid;
    wire logic [ENT_W-1:0] fifo_out;
    wire logic [IDX_W-1:0] p_idx;
    wire logic [BE_W-1:0] p_be;
    wire logic [DATA_W-1:0] p_data;
    wire logic [DATA_W-1:0] merged;
    wire logic commit;

    assign in_range = (addr_ff[35:IDX_W+2] == '0);
    assign ord_word = order_ff ? (addr_ff[3:2] ^ beat_ff) :
        (addr_ff[3:2] + beat_ff);
    assign idx = {addr_ff[IDX_W+1:4], ord_word};
    assign at_last = (beat_ff == (burst_ff ? BEAT_LAST_BURST :
        BEAT_LAST_SINGLE));
    assign take_addr = (state_ff == CEBP_T_IDLE) && bus.address_valid;
    // Reads wait for posted writes so they never return stale data
    assign rd_go = (state_ff == CEBP_T_READ) && !fifo_out_valid;
    assign wr_go = (state_ff == CEBP_T_WRITE) && fifo_in_ready;

    assign bus.address_ready = (state_ff == CEBP_T_IDLE);
    assign bus.subblock_order_select = order_ff; // RQ2
    assign bus.read_data_valid = rdv_ff; // RQ6
    assign bus.read_data_bus = rdata_ff;
    assign bus.read_bus_error = rberr_ff; // RQ9
    assign bus.write_data_ready = wr_go; // RQ7
    assign bus.write_bus_error = wr_go && !in_range; // RQ10
    // Low from the cycle after a push until drained
    assign bus.external_buffers_empty = !fifo_out_valid; // RQ11 RQ12

    cebp_fifo #(
        .WIDTH(ENT_W),
        .DEPTH(DEPTH)
    ) u_wbuf (
        .sys_clk_in,
        .nrst_in,
        .in_valid_in(wr_go),
        .in_data_in({in_range, idx, bus.byte_lane_enables,
            bus.write_data_bus}),
        .in_ready_out(fifo_in_ready),
        .out_valid_out(fifo_out_valid),
        .out_data_out(fifo_out),
        .out_ready_in(!drain_hold_in)
    );

    assign p_data = fifo_out[DATA_W-1:0];
    assign p_be = fifo_out[DATA_W +: BE_W];
    assign p_idx = fifo_out[DATA_W+BE_W +: IDX_W];
    assign commit = fifo_out_valid && !drain_hold_in &&
        fifo_out[ENT_W-1];

    genvar lane;
    generate
        for (lane = 0; lane < BE_W; lane++)
        begin : g_lane
            assign merged[lane*LANE_W +: LANE_W] = p_be[lane] ?
                p_data[lane*LANE_W +: LANE_W] :
                mem_ff[p_idx][lane*LANE_W +: LANE_W]; // RQ3
        end
    endgenerate

    always_ff @(posedge sys_clk_in)
    begin
        if (commit)
            mem_ff[p_idx] <= merged;
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            state_ff <= CEBP_T_IDLE;
        else
            case (state_ff)
                CEBP_T_IDLE:
                    if (take_addr)
                        state_ff <= bus.write ? CEBP_T_WRITE : CEBP_T_READ;
                CEBP_T_READ:
                    if (rd_go && at_last)
                        state_ff <= CEBP_T_IDLE;
                CEBP_T_WRITE:
                    if (wr_go && at_last)
                        state_ff <= CEBP_T_IDLE;
                default:
                    state_ff <= CEBP_T_IDLE;
            endcase
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            addr_ff <= BUS_ADDR_ZERO;
            burst_ff <= 1'b0;
            beat_ff <= BEAT_FIRST;
            order_meta_ff <= 1'b0;
            order_ff <= 1'b0;
        end
        else
        begin
            order_meta_ff <= order_select_in;
            order_ff <= order_meta_ff;
            if (take_addr)
            begin
                addr_ff <= bus.bus_word_address;
                burst_ff <= bus.burst;
                beat_ff <= BEAT_FIRST;
            end
            else if (rd_go || wr_go)
                beat_ff <= beat_ff + BEAT_STEP;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rdv_ff <= 1'b0;
            rberr_ff <= 1'b0;
            rdata_ff <= DATA_ZERO;
        end
        else
        begin
            rdv_ff <= rd_go; // RQ6
            rberr_ff <= rd_go && !in_range; // RQ9
            if (rd_go)
                rdata_ff <= in_range ? mem_ff[idx] : DATA_ZERO;
        end
    end
endmodule
